/* File: shared/fswp_pkg.sv */
// Constants, opcodes and carrier types of the flash status write-protect block
package fswp_pkg;

   // Register port map (word index on the plain port)
   localparam logic [3:0]  ADDR_STATUS           = 4'h0;
   localparam logic [3:0]  ADDR_FUNC             = 4'h1;
   localparam logic [3:0]  ADDR_CFG              = 4'h2;
   localparam logic [3:0]  ADDR_INFO             = 4'h3;

   // Status byte layout
   localparam int          WEL_BIT               = 1;
   localparam int          BLOCK_PROTECT_LSB     = 2;
   localparam int          QUAD_ENABLE_BIT       = 6;
   localparam int          STATUS_WR_DIS_BIT     = 7;
   localparam logic [7:0]  STATUS_WR_MASK        = 8'hfc;
   localparam logic [7:0]  STATUS_RST            = 8'h00;

   // Function and configuration layout
   localparam int          TOP_BOTTOM_SELECT_BIT = 1;
   localparam int          BIG_BLOCK_BIT         = 0;
   localparam logic        TBS_RST               = 1'b0;
   localparam logic        BIG_BLOCK_RST         = 1'b0;

   // Array geometry
   localparam int          BLK64_LSB             = 16;
   localparam int          BLK256_LSB            = 18;
   localparam logic [10:0] NBLK64                = 11'h400;
   localparam logic [10:0] NBLK256               = 11'h100;

   // Command opcodes
   localparam logic [7:0]  VOL_STATUS_ENABLE_CMD        = 8'h50;
   localparam logic [7:0]  STATUS_WRITE_CMD             = 8'h01;
   localparam logic [7:0]  WRITE_LATCH_SET_CMD          = 8'h06;
   localparam logic [7:0]  WHOLE_ARRAY_ERASE_CMD        = 8'hc7;
   localparam logic [7:0]  WHOLE_ARRAY_ERASE_ALT_CMD    = 8'h60;
   localparam logic [7:0]  VOLATILE_READ_PARAM_SET_CMD  = 8'hc0;
   localparam logic [7:0]  VOLATILE_BANK_ADDR_WRITE_CMD = 8'h17;
   localparam logic [7:0]  FUNC_WRITE_CMD               = 8'h42;

   // Command from the decoder
   typedef struct packed {
      logic        valid;
      logic [7:0]  op;
      logic [31:0] addr;
      logic [7:0]  data;
   } fswp_cmd_t;

   // Request to the array engine
   typedef struct packed {
      logic        go;
      logic [7:0]  op;
      logic [31:0] addr;
   } fswp_arr_t;

endpackage

/* File: hw/fswp_top.sv */
// Status register protection logic of a serial NOR flash
`timescale 1ns/1ps
// What this block does
// - Volatile status write needs the volatile status enable command just before it
// - Volatile read parameter and bank address writes need no write latch
// - Nonzero protect code blocks program and erase inside selected region
// - Whole array erase ignored unless all four protect bits are zero
// - Write disable bit clear: status writable whatever the protect pin
// - Write disable set, protect pin low and quad enable clear: status write ignored
// - Write disable set and protect pin high: status write allowed
// - Quad enable clear: protect and hold pins keep control functions
// - Quad enable set: those pins become data lines two and three
// - Small blocks: code n up to 10 protects 2^(n-1), top ends 1023
// - Small blocks: codes 11 to 15 protect 768, 896, 960, 992, 1024
// - Bottom selection: region starts at block 0, same block count
// - Large blocks: codes 1 to 8 protect 1 to 128, top ends 255
// - Large blocks: codes 9 to 15 protect all 256 blocks
// - Top/bottom select resets to top and once set never clears
module fswp_top (
   input  wire logic              clk_sys,      // System clock, 40 MHz
   input  wire logic              nrst,         // Async reset, active low
   input  wire logic [3:0]        regAddr,      // Register index
   input  wire logic [31:0]       regWdata,     // Register write data
   input  wire logic              regWr,        // Register write strobe
   input  wire logic              regRd,        // Register read strobe
   output logic      [31:0]       regRdata,     // Read data, cycle after strobe
   input  wire fswp_pkg::fswp_cmd_t cmdIn,      // Decoded command
   output fswp_pkg::fswp_arr_t    arrReq,       // Array operation request
   output logic                   cmdRejected,  // Command refused, pulse
   output logic                   paramGo,      // Volatile parameter write, pulse
   input  wire logic              wpPin,        // Protect pin / data line 2 input
   input  wire logic              holdPin,      // Hold pin / data line 3 input
   output logic                   wpLevel,      // Protect function level
   output logic                   holdLevelN,   // Hold function level, low holds
   input  wire logic              engLine2Out,  // Engine data for line 2
   input  wire logic              engLine2Oe,   // Engine drive request line 2
   input  wire logic              engLine3Out,  // Engine data for line 3
   input  wire logic              engLine3Oe,   // Engine drive request line 3
   output logic                   dataLine2Out, // Data line 2 output
   output logic                   dataLine2Oe,  // Data line 2 output enable
   output logic                   dataLine3Out, // Data line 3 output
   output logic                   dataLine3Oe   // Data line 3 output enable
);
   import fswp_pkg::*;

   typedef struct packed {
      logic [2:0]  wpSync;
      logic        wpStable;
      logic [2:0]  holdSync;
      logic        holdStable;
      logic [7:0]  statusNv;
      logic [7:0]  statusVol;
      logic        wel;
      logic        volArm;
      logic        topBottomSelect;
      logic        bigBlocks;
      logic [31:0] rdData;
      fswp_arr_t   arr;
      logic        rejected;
      logic        paramGo;
      logic        wpFunc;
      logic        holdFuncN;
      logic        line2Out;
      logic        line2Oe;
      logic        line3Out;
      logic        line3Oe;
      logic [9:0]  lastBlk;
      logic [7:0]  rejCount;
   } fswp_state_t;

   fswp_state_t st_reg;
   fswp_state_t st_next;

   // Protected block count for a code in the selected organisation
   function automatic logic [10:0] protCount(input logic [3:0] code, input logic big);
      logic [10:0] cnt;
      cnt = 11'h000;
      if (code == 4'h0) begin
         cnt = 11'h000;
      end else if (big) begin
         if (code >= 4'h9) begin
            cnt = NBLK256;
         end else begin
            cnt = 11'h001 << (code - 4'h1);
         end
      end else begin
         unique case (code)
            4'hb:    cnt = 11'h300;
            4'hc:    cnt = 11'h380;
            4'hd:    cnt = 11'h3c0;
            4'he:    cnt = 11'h3e0;
            4'hf:    cnt = NBLK64;
            default: cnt = 11'h001 << (code - 4'h1);
         endcase
      end
      return cnt;
   endfunction

   logic [3:0]  bpCode;
   logic        quadOn;
   logic        srLocked;
   logic [10:0] blkIdx;
   logic [10:0] blkTotal;
   logic [10:0] blkCount;
   logic        protHit;
   logic        isProgErase;
   logic        isChipErase;

   assign bpCode   = st_reg.statusVol[BLOCK_PROTECT_LSB +: 4];
   assign quadOn   = st_reg.statusVol[QUAD_ENABLE_BIT];
   // Lock only while the pin is a protect input
   assign srLocked = st_reg.statusVol[STATUS_WR_DIS_BIT] & ~st_reg.wpStable & ~quadOn;
   assign blkIdx   = st_reg.bigBlocks ? {3'h0, cmdIn.addr[BLK256_LSB +: 8]}
                                      : {1'b0, cmdIn.addr[BLK64_LSB +: 10]};
   assign blkTotal = st_reg.bigBlocks ? NBLK256 : NBLK64;
   assign blkCount = protCount(bpCode, st_reg.bigBlocks);
   assign protHit  = st_reg.topBottomSelect ? (blkIdx < blkCount)
                                            : (blkIdx >= blkTotal - blkCount);
   assign isChipErase = (cmdIn.op == WHOLE_ARRAY_ERASE_CMD) ||
                        (cmdIn.op == WHOLE_ARRAY_ERASE_ALT_CMD);

   always_comb begin
      unique case (cmdIn.op)
         8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e,
         8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc: isProgErase = 1'b1;
         default:                                         isProgErase = 1'b0;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.arr.go   = 1'b0;
      st_next.rejected = 1'b0;
      st_next.paramGo  = 1'b0;
      st_next.rdData   = 32'h0000_0000;

      // Pin synchronisers; a change counts once stages two and three agree
      st_next.wpSync   = {st_reg.wpSync[1:0], wpPin};
      st_next.holdSync = {st_reg.holdSync[1:0], holdPin};
      if (st_reg.wpSync[1] == st_reg.wpSync[2]) begin
         st_next.wpStable = st_reg.wpSync[2];
      end
      if (st_reg.holdSync[1] == st_reg.holdSync[2]) begin
         st_next.holdStable = st_reg.holdSync[2];
      end

      // Pin function selection
      if (quadOn) begin
         st_next.wpFunc    = 1'b1;
         st_next.holdFuncN = 1'b1;
         st_next.line2Out  = engLine2Out;
         st_next.line2Oe   = engLine2Oe;
         st_next.line3Out  = engLine3Out;
         st_next.line3Oe   = engLine3Oe;
      end else begin
         st_next.wpFunc    = st_reg.wpStable;
         st_next.holdFuncN = st_reg.holdStable;
         st_next.line2Out  = 1'b0;
         st_next.line2Oe   = 1'b0;
         st_next.line3Out  = 1'b0;
         st_next.line3Oe   = 1'b0;
      end

      // Command handling
      if (cmdIn.valid) begin
         st_next.volArm = (cmdIn.op == VOL_STATUS_ENABLE_CMD);
         if (cmdIn.op == WRITE_LATCH_SET_CMD) begin
            st_next.wel = 1'b1;
         end else if (cmdIn.op == STATUS_WRITE_CMD) begin
            if (srLocked) begin
               st_next.rejected = 1'b1;
            end else if (st_reg.volArm) begin
               st_next.statusVol = cmdIn.data & STATUS_WR_MASK;
            end else if (st_reg.wel) begin
               st_next.statusNv  = cmdIn.data & STATUS_WR_MASK;
               st_next.statusVol = cmdIn.data & STATUS_WR_MASK;
               st_next.wel       = 1'b0;
            end else begin
               st_next.rejected = 1'b1;
            end
         end else if ((cmdIn.op == VOLATILE_READ_PARAM_SET_CMD) ||
                      (cmdIn.op == VOLATILE_BANK_ADDR_WRITE_CMD)) begin
            st_next.paramGo = 1'b1;
         end else if (cmdIn.op == FUNC_WRITE_CMD) begin
            if (st_reg.wel) begin
               st_next.topBottomSelect = st_reg.topBottomSelect |
                                         cmdIn.data[TOP_BOTTOM_SELECT_BIT];
               st_next.wel = 1'b0;
            end else begin
               st_next.rejected = 1'b1;
            end
         end else if (isChipErase) begin
            if (st_reg.wel && (bpCode == 4'h0)) begin
               st_next.arr.go   = 1'b1;
               st_next.arr.op   = cmdIn.op;
               st_next.arr.addr = cmdIn.addr;
               st_next.wel      = 1'b0;
            end else begin
               st_next.rejected = 1'b1;
            end
         end else if (isProgErase) begin
            st_next.lastBlk = blkIdx[9:0];
            if (st_reg.wel && !protHit) begin
               st_next.arr.go   = 1'b1;
               st_next.arr.op   = cmdIn.op;
               st_next.arr.addr = cmdIn.addr;
               st_next.wel      = 1'b0;
            end else begin
               st_next.rejected = 1'b1;
            end
         end
      end
      if (st_next.rejected) begin
         st_next.rejCount = st_reg.rejCount + 8'h01;
      end

      // Register port
      if (regWr) begin
         unique case (regAddr)
            ADDR_FUNC: st_next.topBottomSelect = st_next.topBottomSelect |
                                                 regWdata[TOP_BOTTOM_SELECT_BIT];
            ADDR_CFG:  st_next.bigBlocks = regWdata[BIG_BLOCK_BIT];
            default:   st_next.bigBlocks = st_next.bigBlocks;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            ADDR_STATUS: st_next.rdData = {24'h000000, st_reg.statusVol[7:2], st_reg.wel, 1'b0};
            ADDR_FUNC:   st_next.rdData = {30'h0, st_reg.topBottomSelect, 1'b0};
            ADDR_CFG:    st_next.rdData = {31'h0, st_reg.bigBlocks};
            ADDR_INFO:   st_next.rdData = {14'h0, st_reg.rejCount, st_reg.lastBlk};
            default:     st_next.rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg                 <= '0;
         st_reg.statusNv        <= STATUS_RST;
         st_reg.statusVol       <= STATUS_RST;
         st_reg.topBottomSelect <= TBS_RST;
         st_reg.bigBlocks       <= BIG_BLOCK_RST;
         st_reg.wpFunc          <= 1'b1;
         st_reg.holdFuncN       <= 1'b1;
         // Hold pin idles high; no false hold after reset
         st_reg.holdSync        <= 3'h7;
         st_reg.holdStable      <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign regRdata     = st_reg.rdData;
   assign arrReq       = st_reg.arr;
   assign cmdRejected  = st_reg.rejected;
   assign paramGo      = st_reg.paramGo;
   assign wpLevel      = st_reg.wpFunc;
   assign holdLevelN   = st_reg.holdFuncN;
   assign dataLine2Out = st_reg.line2Out;
   assign dataLine2Oe  = st_reg.line2Oe;
   assign dataLine3Out = st_reg.line3Out;
   assign dataLine3Oe  = st_reg.line3Oe;

   logic [7:0] statusVolQ;
   assign statusVolQ = st_reg.statusVol;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_vol_enable;
      cmdIn.valid && cmdIn.op == VOL_STATUS_ENABLE_CMD;
   endsequence

   sequence s_status_write;
      cmdIn.valid && cmdIn.op == STATUS_WRITE_CMD;
   endsequence

   property p_vol_write;
      s_vol_enable ##1 (s_status_write and !srLocked)
      |=> statusVolQ == ($past(cmdIn.data) & STATUS_WR_MASK);
   endproperty

   a_vol_status_write: assert property (p_vol_write)
      else $error("volatile status write not taken after enable");

   a_unarmed_write_refused: assert property (
      s_status_write and (!st_reg.volArm && !st_reg.wel) |=> cmdRejected && $stable(statusVolQ))
      else $error("status write without enable was not refused");

   a_param_no_latch: assert property (
      cmdIn.valid && !st_reg.wel && (cmdIn.op == VOLATILE_READ_PARAM_SET_CMD ||
      cmdIn.op == VOLATILE_BANK_ADDR_WRITE_CMD) |=> paramGo && !cmdRejected)
      else $error("volatile parameter write needed a latch");

   a_protect_inhibit: assert property (
      cmdIn.valid && isProgErase && protHit |=> !arrReq.go && cmdRejected)
      else $error("program or erase reached a protected block");

   a_chip_erase_guard: assert property (
      cmdIn.valid && isChipErase && bpCode != 4'h0 |=> !arrReq.go && cmdRejected)
      else $error("whole array erase started with protect bits set");

   a_unlocked_write: assert property (
      s_status_write and (!st_reg.statusVol[STATUS_WR_DIS_BIT] && st_reg.wel && !st_reg.volArm)
      |=> !cmdRejected && statusVolQ == ($past(cmdIn.data) & STATUS_WR_MASK))
      else $error("status write refused while write disable clear");

   a_hw_lock: assert property (
      s_status_write and srLocked |=> cmdRejected && $stable(statusVolQ) && $stable(st_reg.statusNv))
      else $error("locked status register changed");

   a_pin_high_write: assert property (
      s_status_write and (st_reg.statusVol[STATUS_WR_DIS_BIT] && st_reg.wpStable && st_reg.wel)
      |=> !cmdRejected)
      else $error("status write refused with protect pin high");

   a_control_pins: assert property (
      !quadOn && !$past(quadOn) |=> wpLevel == $past(st_reg.wpStable) && !dataLine2Oe && !dataLine3Oe)
      else $error("control pin function lost with quad disabled");

   a_data_pins: assert property (
      quadOn |=> dataLine2Oe == $past(engLine2Oe) && dataLine3Oe == $past(engLine3Oe) && wpLevel)
      else $error("data lines not passed in quad mode");

   a_full_array: assert property (
      cmdIn.valid && isProgErase && bpCode == 4'hf |=> cmdRejected)
      else $error("full array code let an operation through");

   a_big_all: assert property (
      cmdIn.valid && isProgErase && st_reg.bigBlocks && bpCode >= 4'h9 |=> !arrReq.go)
      else $error("large block code above eight did not cover all");

   a_bottom_first: assert property (
      cmdIn.valid && isProgErase && st_reg.wel && st_reg.topBottomSelect && bpCode == 4'h1
      && blkIdx == 11'h001 |=> arrReq.go)
      else $error("bottom region reached past its count");

   a_select_sticky: assert property (
      st_reg.topBottomSelect |=> st_reg.topBottomSelect [*2])
      else $error("top bottom select returned to top");

   a_addr_passed: assert property (
      arrReq.go |-> arrReq.addr == $past(cmdIn.addr) && $past(cmdIn.valid))
      else $error("array request address differs from command");

endmodule

/* File: dv/fswp_host_model.sv */
// Host controller model: issues decoded commands and drives the protect and hold pins
`timescale 1ns/1ps
module fswp_host_model (
   input  wire logic                clk_sys,     // System clock
   input  wire logic                nrst,        // Async reset, active low
   output fswp_pkg::fswp_cmd_t      cmdIn,       // Command to the block
   output logic                     wpPin,       // Protect pin level
   output logic                     holdPin,     // Hold pin level
   input  wire fswp_pkg::fswp_arr_t arrReq,      // Array request seen
   input  wire logic                cmdRejected, // Refusal pulse seen
   input  wire logic                paramGo      // Parameter write pulse seen
);
   import fswp_pkg::*;
   initial begin
      cmdIn   = '0;
      wpPin   = 1'b0;
      holdPin = 1'b1;
   end
   // One command; answer sampled in the cycle after it is taken
   task automatic issue(input logic [7:0] op, input logic [31:0] addr, input logic [7:0] data,
                        output logic [2:0] resp);
      @(posedge clk_sys);
      cmdIn <= '{valid: 1'b1, op: op, addr: addr, data: data};
      @(posedge clk_sys);
      // Released fields no longer show the last command
      cmdIn <= '{valid: 1'b0, op: ~op, addr: ~addr, data: ~data};
      #1;
      resp = {arrReq.go, cmdRejected, paramGo};
   endtask
   // Pin change, then time for the synchroniser to settle
   task automatic setPins(input logic wp, input logic hold);
      @(posedge clk_sys);
      wpPin   <= wp;
      holdPin <= hold;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule

/* File: dv/fswp_top_tb.sv */
// Self-checking testbench of the status write-protect block
`timescale 1ns/1ps
module fswp_top_tb;
   import fswp_pkg::*;
   logic                clk_sys, nrst, regWr, regRd, wpPin, holdPin;
   logic [3:0]          regAddr;
   logic [31:0]         regWdata, regRdata, rd, addr;
   fswp_cmd_t           cmdIn;
   fswp_arr_t           arrReq;
   logic                cmdRejected, paramGo, wpLevel, holdLevelN;
   logic                engLine2Out, engLine2Oe, engLine3Out, engLine3Oe;
   logic                dataLine2Out, dataLine2Oe, dataLine3Out, dataLine3Oe, prot;
   logic [2:0]          r;
   logic [7:0]          progOps [13] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7,
                                         8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc};
   int                  nFail, checkCount, c, n, blk;

   fswp_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmdIn(cmdIn), .arrReq(arrReq),
      .cmdRejected(cmdRejected), .paramGo(paramGo), .wpPin(wpPin), .holdPin(holdPin),
      .wpLevel(wpLevel), .holdLevelN(holdLevelN), .engLine2Out(engLine2Out),
      .engLine2Oe(engLine2Oe), .engLine3Out(engLine3Out), .engLine3Oe(engLine3Oe),
      .dataLine2Out(dataLine2Out), .dataLine2Oe(dataLine2Oe), .dataLine3Out(dataLine3Out),
      .dataLine3Oe(dataLine3Oe));
   fswp_host_model u_host (.clk_sys(clk_sys), .nrst(nrst), .cmdIn(cmdIn), .wpPin(wpPin),
      .holdPin(holdPin), .arrReq(arrReq), .cmdRejected(cmdRejected), .paramGo(paramGo));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr    <= 1'b0;
   endtask
   task automatic regRead(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd   <= 1'b0;
      #1;
      d = regRdata;
   endtask
   // Volatile status write: enable command, then status write
   task automatic setStatus(input logic [7:0] d, output logic [2:0] resp);
      u_host.issue(VOL_STATUS_ENABLE_CMD, 32'h0, 8'h00, resp);
      u_host.issue(STATUS_WRITE_CMD, 32'h0, d, resp);
   endtask
   task automatic latchCmd(input logic [7:0] op, input logic [31:0] a, output logic [2:0] resp);
      u_host.issue(WRITE_LATCH_SET_CMD, 32'h0, 8'h00, resp);
      u_host.issue(op, a, 8'h00, resp);
   endtask
   // Protected block count for a code in either organisation
   function automatic int protCount(input logic big, input int code);
      int bigTab [5] = '{768, 896, 960, 992, 1024};
      if (code == 0) return 0;
      if (big) return (code <= 8) ? (1 << (code - 1)) : 256;
      return (code <= 10) ? (1 << (code - 1)) : bigTab[code - 11];
   endfunction
   task automatic finishTest;
      if (nFail == 0 && checkCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      #(25ns * 20000);
      nFail++;
      finishTest;
   end

   initial begin
      nrst = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      engLine2Out = 1'b1;
      engLine2Oe = 1'b1;
      engLine3Out = 1'b0;
      engLine3Oe = 1'b1;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      regRead(ADDR_STATUS, rd);
      chk("status reset", rd, 32'h0);
      regRead(ADDR_FUNC, rd);
      chk("func reset", rd, 32'h0);
      regRead(ADDR_CFG, rd);
      chk("cfg reset", rd, 32'h0);
      regRead(4'h9, rd);
      chk("unmapped read", rd, 32'h0);
      u_host.issue(STATUS_WRITE_CMD, 32'h0, 8'h3c, r);
      chk("write without enable", r, 3'b010);
      u_host.issue(VOLATILE_READ_PARAM_SET_CMD, 32'h0, 8'h00, r);
      chk("read param set", r, 3'b001);
      u_host.issue(VOLATILE_BANK_ADDR_WRITE_CMD, 32'h0, 8'h00, r);
      chk("bank addr write", r, 3'b001);
      setStatus(8'h3f, r);
      chk("status write", r, 3'b000);
      regRead(ADDR_STATUS, rd);
      chk("status masked", rd, 32'h3c);
      latchCmd(WHOLE_ARRAY_ERASE_CMD, 32'h0, r);
      chk("chip erase locked", r, 3'b010);
      latchCmd(WHOLE_ARRAY_ERASE_ALT_CMD, 32'h0, r);
      chk("chip erase alt locked", r, 3'b010);
      setStatus(8'h00, r);
      latchCmd(WHOLE_ARRAY_ERASE_CMD, 32'h0, r);
      chk("chip erase free", r, 3'b100);
      u_host.setPins(1'b1, 1'b0);
      chk("pins control", {wpLevel, holdLevelN, dataLine2Oe, dataLine3Oe}, 4'b1000);
      setStatus(8'h40, r);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pins data", {dataLine2Out, dataLine2Oe, dataLine3Out, dataLine3Oe}, 4'b1101);
      chk("levels quad", {wpLevel, holdLevelN}, 2'b11);
      @(posedge clk_sys);
      {engLine2Out, engLine2Oe, engLine3Out, engLine3Oe} <= 4'b0110;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pin swap", {dataLine2Out, dataLine2Oe, dataLine3Out, dataLine3Oe}, 4'b0110);
      setStatus(8'h00, r);
      u_host.setPins(1'b0, 1'b1);
      chk("wp low level", wpLevel, 1'b0);
      u_host.issue(WRITE_LATCH_SET_CMD, 32'h0, 8'h00, r);
      u_host.issue(STATUS_WRITE_CMD, 32'h0, 8'h80, r);
      chk("disable set", r, 3'b000);
      setStatus(8'h00, r);
      chk("locked write", r, 3'b010);
      regRead(ADDR_STATUS, rd);
      chk("locked status", rd, 32'h80);
      u_host.setPins(1'b1, 1'b1);
      latchCmd(STATUS_WRITE_CMD, 32'h0, r);
      chk("pin high write", r, 3'b000);
      regRead(ADDR_STATUS, rd);
      chk("pin high status", rd, 32'h0);
      for (int pass = 0; pass < 4; pass++) begin
         if (pass == 2) regWrite(ADDR_FUNC, 32'h2);
         regWrite(ADDR_CFG, {31'h0, pass[0]});
         n = pass[0] ? 256 : 1024;
         for (int code = 0; code < 16; code++) begin
            setStatus(8'(code << 2), r);
            c = protCount(pass[0], code);
            for (int k = 0; k < 2; k++) begin
               blk = pass[1] ? c - 1 + k : n - c - k;
               if (blk >= 0 && blk < n) begin
                  addr = (32'(blk) << (pass[0] ? 18 : 16)) | 32'h123;
                  latchCmd(progOps[(code + k) % 13], addr, r);
                  prot = pass[1] ? (blk < c) : (blk >= n - c);
                  chk("protect", r, {~prot, prot, 1'b0});
                  if (!prot) chk("array addr", arrReq.addr, addr);
                  if (!prot) chk("array op", arrReq.op, progOps[(code + k) % 13]);
               end
            end
         end
      end
      regWrite(ADDR_FUNC, 32'h0);
      regRead(ADDR_FUNC, rd);
      chk("select sticky", rd, 32'h2);
      latchCmd(FUNC_WRITE_CMD, 32'h0, r);
      chk("func write latched", r, 3'b000);
      u_host.issue(FUNC_WRITE_CMD, 32'h0, 8'h02, r);
      chk("func write unlatched", r, 3'b010);
      regRead(ADDR_FUNC, rd);
      chk("select still set", rd, 32'h2);
      regRead(ADDR_INFO, rd);
      chk("last block", {22'h0, rd[9:0]}, 32'h0ff);
      finishTest;
   end
endmodule
